// [design/rbs_sequencer.sv]
`timescale 1ns/10ps

// How it works
// - 100ns to 10us low pulse: digital reset
// - low beyond 10us adds analog reset
// - analog reset turns off supply and pll
// - release restores supply, pll, waits 3ms
// - either reset reboots; analog waits clocks
// - straps sampled after both reset kinds
// - power-up: sense straps, boot 3ms later
// - supply control high enables, low disables
// - long reset forces supply control low
// - select high external, low internal regulator
// - internal mode: supply control drives fet
// - loader runs after reset, power-up, swap
// - sampled straps held in boot sense
// - auto loads from flash; else host
// - after flash load, defaults then execute
// - straps read zero unless pulled up
// - low strap bits choose clock source
// - third strap bit: host or flash boot
// - flash boot takes pin nine as select
// - strap pins free after sensing ends
// - pll locked: raise host event interrupt
// - two serial clock cycles select spi
module rbs_sequencer #(
    parameter int POR_DELAY_CYC = rbs_pkg::POR_DELAY_CYC,
    parameter int PLL_START_CYC = rbs_pkg::PLL_START_CYC
) (
    // clock and power-on reset
    input  wire logic       core_clk,
    input  wire logic       srst,
    // reset pin and supply strap
    input  wire logic       reset_n,
    input  wire logic       supply_source_select,
    // bootstrap pins
    input  wire logic [2:0] strap_in,
    // clock and loader status
    input  wire logic       pll_locked,
    input  wire logic       flash_load_done,
    input  wire logic       host_load_done,
    input  wire logic       fw_swap_req,
    // host side
    input  wire logic       host_event_ack,
    input  wire logic       host_sclk,
    // reset and power outputs
    output logic            device_reset,
    output logic            core_supply_control,
    output logic            regulator_internal,
    output logic            pll_enable,
    // strap results
    output logic [2:0]      boot_sense,
    output logic [1:0]      clock_source,
    output logic            clock_source_reserved,
    output logic            auto_boot,
    output logic            strap_pulldown_en,
    output logic            strap_pins_free,
    output logic            flash_chip_select_en,
    // boot control
    output logic            flash_load_start,
    output logic            cfg_default_load,
    output logic            host_load_wait,
    output logic            exec_enable,
    // host notification
    output logic            host_interrupt_n,
    output logic            host_port_spi
);

    rbs_pkg::rbs_state_e state;       // current sequencer state
    rbs_pkg::rbs_state_e next_state;  // state after this edge

    logic                        dig_q;       // pin low long enough to reset
    logic                        ana_q;       // pin low beyond analog width
    logic                        delay_run;   // start-up delay running
    logic                        delay_done;  // start-up delay expired
    logic [rbs_pkg::TIMER_W-1:0] delay_limit; // length of the running delay
    logic                        por;         // first boot since power-up
    logic                        analog;      // last reset was analog
    logic                        irq_pend;    // host event pending
    logic                        next_irq;
    logic                        irq_set;     // pll lock seen in loader
    logic                        sclk_prev;   // host clock, one cycle back
    logic                        sclk_rise;
    logic [1:0]                  sclk_cnt;    // host clock rising edges
    logic [1:0]                  next_sclk_cnt;
    logic                        power_off;   // analog reset in force
    logic                        pins_sensing;

    // pulse width measurement on the reset pin
    rbs_cycle_timer #(
        .WIDTH (rbs_pkg::TIMER_W)
    ) u_dig_timer (
        .core_clk (core_clk),
        .srst     (srst),
        .clear    (reset_n),
        .run      (!reset_n),
        .limit    (rbs_pkg::TIMER_W'(rbs_pkg::DIG_MIN_CYC)),
        .done     (dig_q)
    );

    rbs_cycle_timer #(
        .WIDTH (rbs_pkg::TIMER_W)
    ) u_ana_timer (
        .core_clk (core_clk),
        .srst     (srst),
        .clear    (reset_n),
        .run      (!reset_n),
        .limit    (rbs_pkg::TIMER_W'(rbs_pkg::ANA_MIN_CYC)),
        .done     (ana_q)
    );

    // one counter serves both start-up waits; never both at once
    assign delay_run   = (state == rbs_pkg::ST_DELAY) || (state == rbs_pkg::ST_PLL);
    assign delay_limit = (state == rbs_pkg::ST_PLL) ? rbs_pkg::TIMER_W'(PLL_START_CYC)
                                                    : rbs_pkg::TIMER_W'(POR_DELAY_CYC);

    rbs_cycle_timer #(
        .WIDTH (rbs_pkg::TIMER_W)
    ) u_delay_timer (
        .core_clk (core_clk),
        .srst     (srst),
        .clear    (!delay_run),
        .run      (delay_run),
        .limit    (delay_limit),
        .done     (delay_done)
    );

    assign power_off = ana_q && !reset_n;

    // pins stay inputs with pulls on until sensing completes
    assign pins_sensing = (next_state == rbs_pkg::ST_RESET) ||
                          (next_state == rbs_pkg::ST_PLL) ||
                          (next_state == rbs_pkg::ST_SENSE);

    // next state; a qualified reset pin overrides everything
    always_comb
    begin
        next_state = state;
        unique case (state)
            rbs_pkg::ST_SENSE:  next_state = por ? rbs_pkg::ST_DELAY : rbs_pkg::ST_LOADER;
            rbs_pkg::ST_DELAY:  if (delay_done) next_state = rbs_pkg::ST_LOADER;
            // wait for clocks, then pick source
            rbs_pkg::ST_LOADER:
                if (pll_locked)
                    next_state = auto_boot ? rbs_pkg::ST_FLASH : rbs_pkg::ST_HOST;
            rbs_pkg::ST_FLASH:  if (flash_load_done) next_state = rbs_pkg::ST_CFG;
            rbs_pkg::ST_CFG:    next_state = rbs_pkg::ST_RUN;
            rbs_pkg::ST_HOST:   if (host_load_done) next_state = rbs_pkg::ST_RUN;
            rbs_pkg::ST_RUN:    if (fw_swap_req) next_state = rbs_pkg::ST_HOST;
            // only analog goes through the pll wait
            rbs_pkg::ST_RESET:
                if (reset_n)
                    next_state = analog ? rbs_pkg::ST_PLL : rbs_pkg::ST_SENSE;
            rbs_pkg::ST_PLL:    if (delay_done) next_state = rbs_pkg::ST_SENSE;
            default:            next_state = rbs_pkg::ST_SENSE;
        endcase
        // short glitches never reach here; a pulse of exactly the
        // minimum width is already released when dig_q rises
        if (dig_q && (!reset_n || state != rbs_pkg::ST_RESET))
            next_state = rbs_pkg::ST_RESET;
    end

    // host event: set wins over the host's acknowledge
    assign irq_set  = (state == rbs_pkg::ST_LOADER) && pll_locked && reset_n;
    assign next_irq = (next_state == rbs_pkg::ST_RESET) ? 1'b0 :
                      irq_set ? 1'b1 :
                      host_event_ack ? 1'b0 : irq_pend;

    // serial clock edge count while the host may load
    assign sclk_rise     = host_sclk && !sclk_prev;
    assign next_sclk_cnt = (next_state == rbs_pkg::ST_RESET) ? 2'h0 :
                           (state == rbs_pkg::ST_HOST && sclk_rise &&
                            sclk_cnt != rbs_pkg::SPI_EDGES) ? sclk_cnt + 2'h1 : sclk_cnt;

    // state and bookkeeping flags
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state     <= rbs_pkg::ST_SENSE;
            por       <= 1'b1;
            analog    <= 1'b0;
            irq_pend  <= 1'b0;
            sclk_prev <= 1'b0;
            sclk_cnt  <= 2'h0;
        end
        else
        begin
            state     <= next_state;
            por       <= por && (state != rbs_pkg::ST_DELAY || !delay_done) &&
                         (next_state != rbs_pkg::ST_RESET);
            // remember that this reset was analog
            analog    <= power_off || (analog && state != rbs_pkg::ST_SENSE);
            irq_pend  <= next_irq;
            sclk_prev <= host_sclk;
            sclk_cnt  <= next_sclk_cnt;
        end
    end

    // power outputs; supply and pll return on release
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            device_reset        <= 1'b1;
            core_supply_control <= 1'b1;
            regulator_internal  <= 1'b0;
            pll_enable          <= 1'b1;
        end
        else
        begin
            device_reset        <= (next_state == rbs_pkg::ST_RESET);
            core_supply_control <= !power_off;
            pll_enable          <= !power_off;
            // internal mode means the output drives the fet
            regulator_internal  <= !supply_source_select;
        end
    end

    // strap capture; held until the next sense state, flash select dropped on reset entry
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            boot_sense            <= 3'h0;
            clock_source          <= rbs_pkg::CLK_XTAL_12M;
            clock_source_reserved <= 1'b0;
            auto_boot             <= 1'b0;
            flash_chip_select_en  <= 1'b0;
        end
        else if (state == rbs_pkg::ST_SENSE)
        begin
            boot_sense            <= strap_in;
            // clock source from the low pair
            clock_source          <= strap_in[rbs_pkg::STRAP_CLK_LSB +: 2];
            clock_source_reserved <= strap_in[rbs_pkg::STRAP_CLK_LSB +: 2] == rbs_pkg::CLK_RSVD;
            // boot source; pin nine becomes flash select
            auto_boot             <= strap_in[rbs_pkg::STRAP_BOOT_BIT];
            flash_chip_select_en  <= strap_in[rbs_pkg::STRAP_BOOT_BIT];
        end
        else if (next_state == rbs_pkg::ST_RESET)
        begin
            flash_chip_select_en  <= 1'b0;
        end
    end

    // boot control and host outputs, all registered
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            strap_pulldown_en <= 1'b1;
            strap_pins_free   <= 1'b0;
            flash_load_start  <= 1'b0;
            cfg_default_load  <= 1'b0;
            host_load_wait    <= 1'b0;
            exec_enable       <= 1'b0;
            host_interrupt_n  <= 1'b1;
            host_port_spi     <= 1'b0;
        end
        else
        begin
            // pulls keep an open strap at zero
            strap_pulldown_en <= pins_sensing;
            strap_pins_free   <= !pins_sensing;
            flash_load_start  <= (state == rbs_pkg::ST_LOADER) &&
                                 (next_state == rbs_pkg::ST_FLASH);
            cfg_default_load  <= (next_state == rbs_pkg::ST_CFG);
            host_load_wait    <= (next_state == rbs_pkg::ST_HOST);
            exec_enable       <= (next_state == rbs_pkg::ST_RUN);
            host_interrupt_n  <= !next_irq;
            // spi once two clock cycles were seen
            host_port_spi     <= (next_sclk_cnt == rbs_pkg::SPI_EDGES);
        end
    end

    // checks next to the logic they guard
    dig_entry_a: assert property (
        @(posedge core_clk) disable iff (srst)
        (!reset_n)[*6] |=> device_reset)
        else $error("held reset pin did not reset the device");

    pulse_min_a: assert property (
        @(posedge core_clk) disable iff (srst)
        reset_n ##1 (!reset_n)[*5] ##1 reset_n |=> device_reset)
        else $error("minimum width reset pulse ignored");

    supply_off_a: assert property (
        @(posedge core_clk) disable iff (srst)
        (ana_q && !reset_n) |=> !core_supply_control)
        else $error("supply control stayed high in analog reset");

    pll_off_a: assert property (
        @(posedge core_clk) disable iff (srst)
        !core_supply_control |-> !pll_enable)
        else $error("pll left running with supply off");

    supply_back_a: assert property (
        @(posedge core_clk) disable iff (srst)
        (state == rbs_pkg::ST_RESET && reset_n && analog) |=>
        (core_supply_control && pll_enable && state == rbs_pkg::ST_PLL))
        else $error("supply or pll not restored on release");

    strap_take_a: assert property (
        @(posedge core_clk) disable iff (srst)
        (state == rbs_pkg::ST_SENSE) |=> (boot_sense == $past(strap_in)))
        else $error("boot sense does not match sampled straps");

    strap_hold_a: assert property (
        @(posedge core_clk) disable iff (srst)
        (state != rbs_pkg::ST_SENSE) |=> $stable(boot_sense))
        else $error("boot sense changed outside sensing");

    clk_decode_a: assert property (
        @(posedge core_clk) disable iff (srst)
        clock_source_reserved == (boot_sense[1:0] == rbs_pkg::CLK_RSVD))
        else $error("reserved clock code flag wrong");

    irq_event_a: assert property (
        @(posedge core_clk) disable iff (srst)
        irq_set |=> !host_interrupt_n)
        else $error("host not told after pll lock");

    flash_cs_a: assert property (
        @(posedge core_clk) disable iff (srst)
        (state == rbs_pkg::ST_FLASH) |-> (flash_chip_select_en && auto_boot))
        else $error("flash load without pin nine takeover");

    spi_pick_a: assert property (
        @(posedge core_clk) disable iff (srst)
        $rose(host_port_spi) |-> ($past(sclk_rise) && $past(state) == rbs_pkg::ST_HOST))
        else $error("spi chosen outside a host clock edge");

endmodule

// [design/rbs_pkg.sv]
// shared constants for the reset and boot sequencer
package rbs_pkg;

    // core clock period
    localparam int CLK_PERIOD_NS = 20;

    // reset pulse widths and start-up delays, in their own units
    localparam int T_DIG_MIN_NS  = 100;   // shortest pulse that resets
    localparam int T_ANA_MIN_NS  = 10000; // analog reset beyond this width
    localparam int T_PLL_START_MS = 3;    // pll start-up after supply returns
    localparam int T_POR_DELAY_MS = 3;    // strap sense to boot at power-up

    // least times round up; analog must be strictly longer, so one more
    localparam int DIG_MIN_CYC = (T_DIG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ANA_MIN_CYC = T_ANA_MIN_NS / CLK_PERIOD_NS + 1;
    localparam int PLL_START_CYC = (T_PLL_START_MS * 1000000) / CLK_PERIOD_NS;
    localparam int POR_DELAY_CYC = (T_POR_DELAY_MS * 1000000) / CLK_PERIOD_NS;

    // width of the delay counters
    localparam int TIMER_W = 18;

    // strap field positions
    localparam int STRAP_W        = 3;
    localparam int STRAP_CLK_LSB  = 0;
    localparam int STRAP_BOOT_BIT = 2;

    // clock source codes
    localparam logic [1:0] CLK_XTAL_12M = 2'h0;
    localparam logic [1:0] CLK_FS_8K    = 2'h1;
    localparam logic [1:0] CLK_FS_16K   = 2'h2;
    localparam logic [1:0] CLK_RSVD     = 2'h3;

    // host port: serial clock rising edges that mean spi
    localparam logic [1:0] SPI_EDGES = 2'h2;

    // sequencer states, one-hot
    typedef enum logic [8:0] {
        ST_SENSE  = 9'h001,
        ST_DELAY  = 9'h002,
        ST_LOADER = 9'h004,
        ST_FLASH  = 9'h008,
        ST_CFG    = 9'h010,
        ST_HOST   = 9'h020,
        ST_RUN    = 9'h040,
        ST_RESET  = 9'h080,
        ST_PLL    = 9'h100
    } rbs_state_e;

endpackage

// [design/rbs_cycle_timer.sv]
`timescale 1ns/10ps

// counts cycles while run is high; done sticks once limit is reached
module rbs_cycle_timer #(
    parameter int WIDTH = 18
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             srst,
    // control
    input  wire logic             clear,
    input  wire logic             run,
    input  wire logic [WIDTH-1:0] limit,
    // status
    output logic                  done
);

    logic [WIDTH-1:0] count;      // cycles seen so far
    logic             last_step;  // this step reaches the limit

    assign last_step = (count == (limit - 1'b1));

    // saturating count; clear has priority over run
    always_ff @(posedge core_clk)
    begin
        if (srst || clear)
        begin
            count <= '0;
            done  <= 1'b0;
        end
        else if (run && !done)
        begin
            count <= count + 1'b1;
            done  <= last_step;
        end
    end

endmodule

// [bench/rbs_host_model.sv]
`timescale 1ns/10ps

// far side: clock source, flash and host loader, all driven at the falling edge
module rbs_host_model #(
    parameter int LOCK_CYC = 8,
    parameter int LOAD_CYC = 6
) (
    // clock
    input  wire logic core_clk,
    // device status seen by the far side
    input  wire logic pll_enable,
    input  wire logic flash_load_start,
    input  wire logic host_load_wait,
    // bench knobs
    input  wire logic slow,
    input  wire logic use_spi,
    // answers
    output logic      pll_locked,
    output logic      flash_load_done,
    output logic      host_load_done,
    output logic      host_sclk
);
    int lcnt; // cycles since pll enabled
    int fcnt; // flash copy countdown
    int hcnt; // cycles spent in host wait

    initial
    begin
        pll_locked = 1'b0;
        flash_load_done = 1'b0;
        host_load_done = 1'b0;
        host_sclk = 1'b0;
        lcnt = 0;
        fcnt = 0;
        hcnt = 0;
    end

    always @(negedge core_clk)
    begin
        if (pll_enable !== 1'b1)
        begin
            lcnt = 0;
            pll_locked <= 1'b0;
        end
        else if (lcnt < LOCK_CYC)
            lcnt++;
        else
            pll_locked <= 1'b1;
    end

    // flash copy: one done pulse per start, slow mode stretches it
    always @(negedge core_clk)
    begin
        flash_load_done <= 1'b0;
        if (flash_load_start === 1'b1)
            fcnt = slow ? 4 * LOAD_CYC : LOAD_CYC;
        else if (fcnt > 1)
            fcnt--;
        else if (fcnt == 1)
        begin
            fcnt = 0;
            flash_load_done <= 1'b1;
        end
    end

    always @(negedge core_clk)
    begin
        host_load_done <= 1'b0;
        if (host_load_wait !== 1'b1)
        begin
            hcnt = 0;
            host_sclk <= 1'b0;
        end
        else
        begin
            hcnt++;
            // two rising edges only, then idle low; i2c mode never toggles
            host_sclk <= use_spi && hcnt < 9 && hcnt[1];
            if (hcnt == 12 + (slow ? 4 * LOAD_CYC : LOAD_CYC))
                host_load_done <= 1'b1;
        end
    end
endmodule

// [bench/tb_top.sv]
`timescale 1ns/10ps

module tb_top;
    localparam int POR_CYC = 20;   // shortened power-up delay
    localparam int PLL_CYC = 20;   // shortened pll start-up
    localparam int LIM     = 3000; // bound on any single wait

    // stimulus
    logic       core_clk, srst, reset_n, supply_source_select;
    logic [2:0] strap_in;
    logic       fw_swap_req, host_event_ack, slow, use_spi;
    // partner answers
    logic       pll_locked, flash_load_done, host_load_done, host_sclk;
    // design outputs
    logic       device_reset, core_supply_control, regulator_internal, pll_enable;
    logic [2:0] boot_sense;
    logic [1:0] clock_source;
    logic       clock_source_reserved, auto_boot, strap_pulldown_en, strap_pins_free;
    logic       flash_chip_select_en, flash_load_start, cfg_default_load;
    logic       host_load_wait, exec_enable, host_interrupt_n, host_port_spi;
    // bookkeeping
    int         errors, cmp_count, n, i;
    logic       saw_cfg, saw_flash;
    logic [2:0] tbl [4] = '{3'b100, 3'b001, 3'b110, 3'b011};

    rbs_sequencer #(.POR_DELAY_CYC(POR_CYC), .PLL_START_CYC(PLL_CYC)) i_rbs_sequencer (
        .core_clk(core_clk), .srst(srst), .reset_n(reset_n),
        .supply_source_select(supply_source_select), .strap_in(strap_in),
        .pll_locked(pll_locked), .flash_load_done(flash_load_done),
        .host_load_done(host_load_done), .fw_swap_req(fw_swap_req),
        .host_event_ack(host_event_ack), .host_sclk(host_sclk),
        .device_reset(device_reset), .core_supply_control(core_supply_control),
        .regulator_internal(regulator_internal), .pll_enable(pll_enable),
        .boot_sense(boot_sense), .clock_source(clock_source),
        .clock_source_reserved(clock_source_reserved), .auto_boot(auto_boot),
        .strap_pulldown_en(strap_pulldown_en), .strap_pins_free(strap_pins_free),
        .flash_chip_select_en(flash_chip_select_en), .flash_load_start(flash_load_start),
        .cfg_default_load(cfg_default_load), .host_load_wait(host_load_wait),
        .exec_enable(exec_enable), .host_interrupt_n(host_interrupt_n),
        .host_port_spi(host_port_spi));

    rbs_host_model i_rbs_host_model (
        .core_clk(core_clk), .pll_enable(pll_enable), .flash_load_start(flash_load_start),
        .host_load_wait(host_load_wait), .slow(slow), .use_spi(use_spi),
        .pll_locked(pll_locked), .flash_load_done(flash_load_done),
        .host_load_done(host_load_done), .host_sclk(host_sclk));

    // 50 MHz core clock
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // compare and count; case equality so unknowns never match
    task check(input string name, input logic [2:0] seen, input logic [2:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // counts, verdict, end of run
    task complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // bounded wait for run (0) or host wait (1), noting loader pulses
    task automatic wait_for(input int which, output int cnt);
        cnt = 0;
        saw_cfg = 1'b0;
        saw_flash = 1'b0;
        while (cnt < LIM && (which == 0 ? exec_enable : host_load_wait) !== 1'b1)
        begin
            @(negedge core_clk);
            cnt++;
            if (cfg_default_load === 1'b1)
                saw_cfg = 1'b1;
            if (flash_load_start === 1'b1)
                saw_flash = 1'b1;
        end
        check("wait_done", 3'(cnt < LIM), 3'h1);
    endtask

    // strap results after a boot, then event raise and acknowledge
    task automatic check_straps(input logic [2:0] s);
        logic a;
        a = s[rbs_pkg::STRAP_BOOT_BIT];
        check("boot_sense", boot_sense, s);
        check("clock_source", 3'(clock_source), 3'(s[1:0]));
        check("clock_rsvd", 3'(clock_source_reserved), 3'(s[1:0] == rbs_pkg::CLK_RSVD));
        check("auto_boot", 3'(auto_boot), 3'(a));
        check("flash_cs", 3'(flash_chip_select_en), 3'(a));
        check("flash_load", 3'(saw_flash), 3'(a));
        check("cfg_load", 3'(saw_cfg), 3'(a));
        check("spi_port", 3'(host_port_spi), 3'(!a && use_spi));
        check("pins_free", 3'(strap_pins_free), 3'h1);
        check("irq_set", 3'(host_interrupt_n), 3'h0);
        host_event_ack = 1'b1;
        @(negedge core_clk);
        host_event_ack = 1'b0;
        @(negedge core_clk);
        check("irq_clear", 3'(host_interrupt_n), 3'h1);
        $display("test boot %b done", s);
    endtask

    // pin reset of a given width, then a full reboot with straps s
    task automatic boot_case(input logic [2:0] s, input int width);
        int k;
        int m;
        strap_in = s;
        reset_n = 1'b0;
        for (k = 1; k <= width; k++)
        begin
            @(negedge core_clk);
            if (k == 505)
            begin
                check("supply_off", 3'(core_supply_control), 3'h0);
                check("pll_off", 3'(pll_enable), 3'h0);
            end
        end
        check("device_reset", 3'(device_reset), 3'h1);
        check("pulldown_rst", 3'(strap_pulldown_en), 3'h1);
        check("exec_in_reset", 3'(exec_enable), 3'h0);
        check("supply_kept", 3'(core_supply_control), 3'(width < 500));
        reset_n = 1'b1;
        repeat (2) @(negedge core_clk);
        check("supply_back", 3'(core_supply_control), 3'h1);
        check("pll_back", 3'(pll_enable), 3'h1);
        wait_for(0, m);
        check("pll_wait", 3'(m >= (width > 501 ? PLL_CYC - 2 : 0)), 3'h1);
        check_straps(s);
    endtask

    // main sequence, all inputs change on the falling edge
    initial
    begin
        errors = 0;
        cmp_count = 0;
        srst = 1'b1;
        reset_n = 1'b1;
        supply_source_select = 1'b1;
        strap_in = 3'b101;
        fw_swap_req = 1'b0;
        host_event_ack = 1'b0;
        slow = 1'b0;
        use_spi = 1'b1;
        repeat (20) @(negedge core_clk);
        check("pulldown", 3'(strap_pulldown_en), 3'h1);
        check("supply_on", 3'(core_supply_control), 3'h1);
        check("reg_ext", 3'(regulator_internal), 3'h0);
        srst = 1'b0;
        wait_for(0, n);
        check("por_delay", 3'(n >= POR_CYC), 3'h1);
        check_straps(3'b101);
        // a three-cycle glitch must not reboot
        reset_n = 1'b0;
        repeat (3) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge core_clk);
        check("short_pulse", 3'(exec_enable), 3'h1);
        $display("test glitch done");
        // a pulse of exactly the minimum width must reboot
        reset_n = 1'b0;
        repeat (5) @(negedge core_clk);
        reset_n = 1'b1;
        @(negedge core_clk);
        check("min_pulse", 3'(device_reset), 3'h1);
        wait_for(0, n);
        check_straps(3'b101);
        // straps move while running, then a firmware swap
        strap_in = 3'b010;
        fw_swap_req = 1'b1;
        @(negedge core_clk);
        fw_swap_req = 1'b0;
        wait_for(1, n);
        wait_for(0, n);
        check("swap_keep", boot_sense, 3'b101);
        $display("test swap done");
        // every clock code, both boot sources, short and mid widths
        for (i = 0; i < 4; i++)
        begin
            use_spi = (i != 3);
            slow = i[0];
            boot_case(tbl[i], i[1] ? 100 : 10);
        end
        // long reset with the internal regulator, default straps
        supply_source_select = 1'b0;
        boot_case(3'b000, 520);
        check("reg_int", 3'(regulator_internal), 3'h1);
        complete_run();
    end

    // hang guard, far past the thousand or so cycles the tests need
    initial
    begin
        repeat (20000) @(posedge core_clk);
        errors++;
        complete_run();
    end
endmodule
